// *** inc/occ_pkg.sv ***
package occ_pkg;
  // base clock and pll lock time
  localparam int CLK_PERIOD_NS = 8;
  localparam int PLL_LOCK_US = 2000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // oscillator mode field codes
  localparam logic [2:0] MODE_INT_PORT = 3'h0;
  localparam logic [2:0] MODE_INT_CLKOUT = 3'h1;
  localparam logic [2:0] MODE_XTAL_PLAIN = 3'h2;
  localparam logic [2:0] MODE_XTAL_PLL = 3'h3;
  localparam logic [2:0] MODE_EXT_PLAIN = 3'h4;
  localparam logic [2:0] MODE_EXT_PLL = 3'h5;
  localparam logic [2:0] MODE_INT_PLL_PORT = 3'h6;
  localparam logic [2:0] MODE_INT_PLL_CLKOUT = 3'h7;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  // control fields
  localparam int CTRL_PLL_ON = 0;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_USB_LS = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // status fields
  localparam int STAT_LOCK = 0;
  localparam int STAT_PLL_PWR = 1;
  localparam int STAT_USB_OK = 2;
  localparam int STAT_ON_PLL = 3;
  localparam int STAT_OSC_ON = 4;
  // configuration fields
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_PRESC_LO = 4;
  localparam int CFG_CDIV_LO = 8;
  // system clock selection
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_POSTSCALED = 2'h1;
  localparam logic [1:0] SEL_TIMER1 = 2'h2;
  // fixed ratios: 96 -> 48 mhz node, 48 -> 6 mhz low speed, clock out = periph / 4
  localparam logic [3:0] PLL_NODE_DIV = 4'h2;
  localparam logic [3:0] USB_LS_DIV = 4'h8;
  localparam logic [3:0] CLKOUT_DIV = 4'h4;

  function automatic logic mode_has_pll(input logic [2:0] m);
    return m == MODE_XTAL_PLL || m == MODE_EXT_PLL || m == MODE_INT_PLL_PORT || m == MODE_INT_PLL_CLKOUT;
  endfunction

  function automatic logic mode_has_clkout(input logic [2:0] m);
    return m == MODE_EXT_PLAIN || m == MODE_EXT_PLL || m == MODE_INT_CLKOUT || m == MODE_INT_PLL_CLKOUT;
  endfunction

  function automatic logic mode_ext_pin(input logic [2:0] m);
    return m == MODE_EXT_PLAIN || m == MODE_EXT_PLL || m == MODE_XTAL_PLAIN || m == MODE_XTAL_PLL;
  endfunction

  // eight input prescaler options
  function automatic logic [3:0] presc_div(input logic [2:0] c);
    case (c)
      3'h0: return 4'h1;
      3'h1: return 4'h2;
      3'h2: return 4'h3;
      3'h3: return 4'h4;
      3'h4: return 4'h5;
      3'h5: return 4'h6;
      3'h6: return 4'ha;
      default: return 4'hc;
    endcase
  endfunction

  // core divider options
  function automatic logic [3:0] cdiv_div(input logic [1:0] c);
    case (c)
      2'h0: return 4'h1;
      2'h1: return 4'h2;
      2'h2: return 4'h3;
      default: return 4'h6;
    endcase
  endfunction
endpackage

// *** logic/occ_tick_div.sv ***
`timescale 1ns/1ns
module occ_tick_div #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ticks
  input wire logic tick_in,
  input wire logic [W-1:0] div,
  output logic tick_out
);
  logic [W-1:0] cnt_r;
  logic last;

  // zero divide acts as one
  assign last = cnt_r >= div - W'(1) || div == '0;
  assign tick_out = tick_in && last;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (tick_in) begin
      cnt_r <= last ? '0 : cnt_r + W'(1);
    end
  end

  a_div_ratio: assert property (@(posedge clk) disable iff (sys_rst)
    tick_out |-> tick_in && (cnt_r == div - W'(1) || div <= W'(1)))
    else $error("divider fired off count");
endmodule // occ_tick_div

// *** logic/occ_tick_sw.sv ***
`timescale 1ns/1ns
module occ_tick_sw (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sources
  input wire logic want_alt,
  input wire logic tick_main,
  input wire logic tick_alt,
  // result
  output logic tick_out,
  output logic on_alt
);
  logic on_alt_r;

  assign on_alt = on_alt_r;
  assign tick_out = on_alt_r ? tick_alt : tick_main;

  // RULE21 switch in quiet cycle
  // changing only while neither source ticks means no doubled or cut tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      on_alt_r <= 1'b0;
    end else if (!tick_main && !tick_alt) begin
      on_alt_r <= want_alt;
    end
  end

  a_sw_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(on_alt_r) |-> !$past(tick_main) && !$past(tick_alt)) // RULE21
    else $error("source switched during a tick");
endmodule // occ_tick_sw

// *** logic/occ_clk_ctrl.sv ***
`timescale 1ns/1ns
// Operation
// RULE1 - eight oscillator modes chosen by a three-bit nonvolatile field
// RULE2 - mode, prescaler and core divider fixed until reprogrammed
// RULE3 - clock output runs at one quarter of peripheral clock
// RULE4 - clock output stops in sleep, keeps running in idle
// RULE5 - external clock modes: clock in on pin one, clock out on pin two
// RULE6 - crystal modes: resonator across both pins, pll only in pll variant
// RULE7 - internal pll modes: internal block gives primary and postscaled clock
// RULE8 - internal plain modes: postscaler output is primary, pll off
// RULE9 - usb gets fixed 6 or 48 mhz
// RULE10 - core clock derived independently of the usb clock
// RULE11 - pll takes 4 mhz reference and gives 96 mhz
// RULE12 - pll off while software enable bit is clear
// RULE13 - until lock, device runs from bypass clock
// RULE14 - full speed needs 48 mhz post-pll node, software's job
// RULE15 - low speed node 48 or 24 mhz, usb must see 6 mhz
// RULE16 - timer1 or postscaled selection shuts pll and primary oscillator; the code keeps the oscillator on while refclk_needs_osc is set
// RULE17 - usb communicates only when primary clock is selected
// RULE18 - core divider divides by 1, 2, 3 or 6
// RULE19 - core moves to pll clock automatically once locked
// RULE20 - eight-option prescaler divides input down to pll reference
// RULE21 - bypass to pll switch without glitch or runt
// RULE22 - pll locked flag after lock interval from enable
module occ_clk_ctrl #(
  parameter int LOCK_CYC = occ_pkg::PLL_LOCK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // nonvolatile configuration
  input wire logic [2:0] nv_osc_mode_field,
  input wire logic [2:0] nv_presc_field,
  input wire logic [1:0] nv_core_divider_field,
  // oscillator sources as tick enables
  input wire logic internal_port_mode_tick,
  input wire logic internal_port_mode_post_tick,
  input wire logic timer1_tick,
  input wire logic pll_out_tick,
  // power manager
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic refclk_needs_osc,
  // oscillator pins
  input wire logic osc_pin_one_in,
  output logic osc_pin_one_out,
  output logic osc_pin_one_oe,
  output logic osc_pin_two_out,
  output logic osc_pin_two_oe,
  // port function of the pins
  input wire logic port_one_out,
  input wire logic port_one_oe,
  input wire logic port_two_out,
  input wire logic port_two_oe,
  // analog controls
  output logic prim_osc_en,
  output logic xtal_drive_en,
  output logic pll_power_en,
  output logic pll_ref_tick,
  // derived clocks
  output logic periph_tick,
  output logic cpu_tick,
  output logic usb_tick,
  output logic usb_clk_ok,
  output logic pll_locked
);
  localparam int LW = $clog2(LOCK_CYC + 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYC - 1);

  logic cfg_loaded_r;
  logic [2:0] osc_mode_field_r;
  logic [2:0] presc_r;
  logic [1:0] core_divider_field_r;
  logic pll_on_bit_r;
  logic [1:0] clk_sel_r;
  logic usb_ls_r;
  logic [LW-1:0] lock_cnt_r;
  logic locked_r;
  logic pin_one_q_r;
  logic clkout_r;
  logic [1:0] clkout_cnt_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic ext_tick;
  logic prim_tick;
  logic pll_en;
  logic node_tick;
  logic pll_core_tick;
  logic primary_tick;
  logic on_pll;
  logic sys_tick;
  logic ls_tick;
  logic has_clkout;
  logic wr_ctrl;
  logic sel_prim;

  // RULE2 one-time capture
  // captured once after reset release; no path rewrites it later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_loaded_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r <= 1'b1;
    end
  end

  // RULE1 mode field capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_mode_field_r <= occ_pkg::MODE_INT_PORT;
      presc_r <= 3'h0;
      core_divider_field_r <= 2'h0;
    end else if (!cfg_loaded_r) begin
      osc_mode_field_r <= nv_osc_mode_field;
      presc_r <= nv_presc_field;
      core_divider_field_r <= nv_core_divider_field;
    end
  end

  // control register
  assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0] && wb_adr_i == occ_pkg::REG_CTRL;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pll_on_bit_r <= occ_pkg::CTRL_RST[occ_pkg::CTRL_PLL_ON];
      clk_sel_r <= occ_pkg::CTRL_RST[occ_pkg::CTRL_SEL_LO +: 2];
      usb_ls_r <= occ_pkg::CTRL_RST[occ_pkg::CTRL_USB_LS];
    end else if (wr_ctrl) begin
      pll_on_bit_r <= wb_dat_i[occ_pkg::CTRL_PLL_ON];
      clk_sel_r <= wb_dat_i[occ_pkg::CTRL_SEL_LO +: 2];
      usb_ls_r <= wb_dat_i[occ_pkg::CTRL_USB_LS];
    end
  end

  // wishbone answer one cycle after the request; unmapped reads as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      dat_r <= 32'h0;
      if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
        case (wb_adr_i)
          occ_pkg::REG_CTRL: begin
            dat_r[occ_pkg::CTRL_PLL_ON] <= pll_on_bit_r;
            dat_r[occ_pkg::CTRL_SEL_LO +: 2] <= clk_sel_r;
            dat_r[occ_pkg::CTRL_USB_LS] <= usb_ls_r;
          end
          occ_pkg::REG_STAT: begin
            dat_r[occ_pkg::STAT_LOCK] <= locked_r;
            dat_r[occ_pkg::STAT_PLL_PWR] <= pll_en;
            dat_r[occ_pkg::STAT_USB_OK] <= usb_clk_ok;
            dat_r[occ_pkg::STAT_ON_PLL] <= on_pll;
            dat_r[occ_pkg::STAT_OSC_ON] <= prim_osc_en;
          end
          occ_pkg::REG_CFG: begin
            dat_r[occ_pkg::CFG_MODE_LO +: 3] <= osc_mode_field_r;
            dat_r[occ_pkg::CFG_PRESC_LO +: 3] <= presc_r;
            dat_r[occ_pkg::CFG_CDIV_LO +: 2] <= core_divider_field_r;
          end
          default: begin
            dat_r <= 32'h0;
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // RULE5 external clock on pin one
  // a rising pin level is one oscillator cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_one_q_r <= 1'b0;
    end else begin
      pin_one_q_r <= osc_pin_one_in;
    end
  end

  assign ext_tick = osc_pin_one_in && !pin_one_q_r;

  // RULE7 internal pll modes use block output
  // RULE8 plain internal modes use postscaler
  always_comb begin
    case (osc_mode_field_r)
      occ_pkg::MODE_INT_PLL_PORT, occ_pkg::MODE_INT_PLL_CLKOUT: prim_tick = internal_port_mode_tick;
      occ_pkg::MODE_INT_PORT, occ_pkg::MODE_INT_CLKOUT: prim_tick = internal_port_mode_post_tick;
      default: prim_tick = ext_tick;
    endcase
  end

  // RULE16 shut down off primary
  // spare select code runs as primary, so it must keep the oscillator up
  assign sel_prim = clk_sel_r != occ_pkg::SEL_POSTSCALED && clk_sel_r != occ_pkg::SEL_TIMER1;
  assign prim_osc_en = sel_prim || refclk_needs_osc;
  // RULE6 crystal drive across both pins
  assign xtal_drive_en = prim_osc_en && (osc_mode_field_r == occ_pkg::MODE_XTAL_PLAIN ||
                                        osc_mode_field_r == occ_pkg::MODE_XTAL_PLL);

  // RULE12 pll gated by enable bit
  assign pll_en = occ_pkg::mode_has_pll(osc_mode_field_r) && pll_on_bit_r && sel_prim;
  assign pll_power_en = pll_en;

  // RULE20 reference prescaler
  occ_tick_div #(.W(4)) u_presc (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(prim_tick && pll_en),
    .div(occ_pkg::presc_div(presc_r)),
    .tick_out(pll_ref_tick)
  );

  // RULE22 lock interval count
  // RULE11 96 mhz output trusted only after lock
  always_ff @(posedge clk) begin
    if (sys_rst || !pll_en) begin
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
    end else if (lock_cnt_r >= LOCK_LAST) begin
      locked_r <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + LW'(1);
    end
  end

  assign pll_locked = locked_r;

  // 96 mhz to 48 mhz node
  occ_tick_div #(.W(4)) u_node (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(pll_out_tick && locked_r),
    .div(occ_pkg::PLL_NODE_DIV),
    .tick_out(node_tick)
  );

  // RULE18 core divider
  // RULE10 core path apart from usb path
  occ_tick_div #(.W(4)) u_cdiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(node_tick),
    .div(occ_pkg::cdiv_div(core_divider_field_r)),
    .tick_out(pll_core_tick)
  );

  // RULE13 bypass until lock
  // RULE19 automatic switch on lock
  occ_tick_sw u_sw (
    .clk(clk),
    .sys_rst(sys_rst),
    .want_alt(locked_r),
    .tick_main(prim_tick),
    .tick_alt(pll_core_tick),
    .tick_out(primary_tick),
    .on_alt(on_pll)
  );

  // system clock source
  always_comb begin
    case (clk_sel_r)
      occ_pkg::SEL_PRIMARY: sys_tick = primary_tick;
      occ_pkg::SEL_POSTSCALED: sys_tick = internal_port_mode_post_tick;
      occ_pkg::SEL_TIMER1: sys_tick = timer1_tick;
      default: sys_tick = primary_tick;
    endcase
  end

  // RULE4 sleep stops, idle keeps peripherals
  assign periph_tick = sys_tick && !sleep_mode;
  assign cpu_tick = periph_tick && !idle_mode;

  // RULE9 48 mhz node or 6 mhz
  // RULE15 low speed taken as node divided to 6 mhz
  occ_tick_div #(.W(4)) u_usb_ls (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(node_tick),
    .div(occ_pkg::USB_LS_DIV),
    .tick_out(ls_tick)
  );

  // RULE17 usb only on primary source
  assign usb_clk_ok = locked_r && sel_prim;
  assign usb_tick = usb_clk_ok && (usb_ls_r ? ls_tick : node_tick);

  // RULE3 clock out divide by four
  // toggles every second peripheral tick; frozen in sleep since periph_tick stops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkout_cnt_r <= 2'h0;
      clkout_r <= 1'b0;
    end else if (periph_tick) begin
      clkout_cnt_r <= clkout_cnt_r + 2'h1;
      if (clkout_cnt_r[0]) begin
        clkout_r <= !clkout_r;
      end
    end
  end

  assign has_clkout = occ_pkg::mode_has_clkout(osc_mode_field_r);

  // RULE5 pin two carries clock out
  // RULE7 port functions where free
  always_comb begin
    osc_pin_one_out = 1'b0;
    osc_pin_one_oe = 1'b0;
    osc_pin_two_out = 1'b0;
    osc_pin_two_oe = 1'b0;
    if (!occ_pkg::mode_ext_pin(osc_mode_field_r)) begin
      osc_pin_one_out = port_one_out;
      osc_pin_one_oe = port_one_oe;
      if (has_clkout) begin
        osc_pin_two_out = clkout_r;
        osc_pin_two_oe = 1'b1;
      end else begin
        osc_pin_two_out = port_two_out;
        osc_pin_two_oe = port_two_oe;
      end
    end else if (has_clkout) begin
      osc_pin_two_out = clkout_r;
      osc_pin_two_oe = 1'b1;
    end
  end

  a_cfg_stays_fixed: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    cfg_loaded_r && $past(cfg_loaded_r) |-> $stable(osc_mode_field_r) && $stable(core_divider_field_r))
    else $error("configuration changed at run time");
  a_pll_plain_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    !occ_pkg::mode_has_pll(osc_mode_field_r) |-> !pll_power_en && !pll_locked)
    else $error("pll on in a plain mode");
  a_pll_bit_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    !pll_on_bit_r |-> ##1 !pll_locked)
    else $error("pll locked with enable clear");
  a_lock_interval: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
    $rose(pll_locked) |-> $past(pll_en) && lock_cnt_r == LOCK_LAST)
    else $error("lock flagged early");
  a_bypass_unlock: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    $rose(on_pll) |-> $past(pll_locked))
    else $error("core on pll before lock");
  a_auto_switch: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
    pll_locked && !prim_tick && !pll_core_tick |=> on_pll || !pll_locked)
    else $error("core did not move to pll");
  a_osc_shutdown: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    !sel_prim |-> !pll_power_en && (prim_osc_en == refclk_needs_osc))
    else $error("primary oscillator left on");
  a_usb_gate: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    usb_tick |-> sel_prim && pll_locked)
    else $error("usb clocked off primary");
  a_clkout_sleep: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    sleep_mode ##1 sleep_mode |-> $stable(clkout_r))
    else $error("clock out ran in sleep");
  a_clkout_quarter: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    $changed(clkout_r) |-> $past(periph_tick) && $past(clkout_cnt_r[0]))
    else $error("clock out not a quarter rate");
  a_clkout_pin: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    has_clkout |-> osc_pin_two_oe && osc_pin_two_out == clkout_r)
    else $error("clock out missing on pin two");

  c_lock_seen: cover property (@(posedge clk) disable iff (sys_rst) $rose(pll_locked));
  c_on_pll: cover property (@(posedge clk) disable iff (sys_rst) $rose(on_pll));
  c_usb_ls: cover property (@(posedge clk) disable iff (sys_rst) usb_tick && usb_ls_r);
  c_ctrl_write: cover property (@(posedge clk) disable iff (sys_rst) wr_ctrl);
endmodule // occ_clk_ctrl

// *** test/occ_osc_src.sv ***
`timescale 1ns/1ns
module occ_osc_src (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pll power from the block
  input wire logic pll_power_en,
  // clock sources
  output logic osc_pin_one_in,
  output logic internal_port_mode_tick,
  output logic internal_port_mode_post_tick,
  output logic timer1_tick,
  output logic pll_out_tick
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // oscillators run free; only the pll needs power
  assign osc_pin_one_in = cnt_r[1];
  assign internal_port_mode_tick = cnt_r[0];
  assign internal_port_mode_post_tick = (cnt_r[1:0] == 2'h0);
  assign timer1_tick = (cnt_r == 4'h0);
  // pll gated by power
  // silent when unpowered, so a bypass path cannot hide behind it
  assign pll_out_tick = pll_power_en;
endmodule // occ_osc_src

// *** test/occ_clk_ctrl_tb_top.sv ***
`timescale 1ns/1ns
module occ_clk_ctrl_tb_top;
  localparam int LK = 20;
  // mode masks by code: pll capable, clock out, crystal, external pin
  localparam logic [7:0] PLL_M = 8'he8;
  localparam logic [7:0] CKO_M = 8'hb2;
  localparam logic [7:0] XT_M = 8'h0c;
  localparam logic [7:0] EXT_M = 8'h3c;
  logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0] nv_osc_mode_field, nv_presc_field;
  logic [1:0] nv_core_divider_field;
  logic internal_port_mode_tick, internal_port_mode_post_tick, timer1_tick, pll_out_tick;
  logic sleep_mode, idle_mode, refclk_needs_osc, osc_pin_one_in;
  logic osc_pin_one_out, osc_pin_one_oe, osc_pin_two_out, osc_pin_two_oe;
  logic port_one_out, port_one_oe, port_two_out, port_two_oe;
  logic prim_osc_en, xtal_drive_en, pll_power_en, pll_ref_tick;
  logic periph_tick, cpu_tick, usb_tick, usb_clk_ok, pll_locked;
  int n_fail = 0;
  int total_checks = 0;
  int c_usb, c_pll, c_per, c_cpu, c_tog, c_ref;

  occ_clk_ctrl #(.LOCK_CYC(LK)) dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .nv_osc_mode_field, .nv_presc_field,
    .nv_core_divider_field, .internal_port_mode_tick, .internal_port_mode_post_tick, .timer1_tick, .pll_out_tick,
    .sleep_mode, .idle_mode, .refclk_needs_osc, .osc_pin_one_in, .osc_pin_one_out,
    .osc_pin_one_oe, .osc_pin_two_out, .osc_pin_two_oe, .port_one_out, .port_one_oe,
    .port_two_out, .port_two_oe, .prim_osc_en, .xtal_drive_en, .pll_power_en, .pll_ref_tick,
    .periph_tick, .cpu_tick, .usb_tick, .usb_clk_ok, .pll_locked);
  occ_osc_src src (.clk, .sys_rst, .pll_power_en, .osc_pin_one_in, .internal_port_mode_tick,
    .internal_port_mode_post_tick, .timer1_tick, .pll_out_tick);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // counts are sampled, so a window edge may cut one tick
  task automatic chk_cnt(input int got, input int exp, input int tol, input string what);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("mismatch at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // ack and read data are taken at the rising edge that sees ack high
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: no ack", $time);
      conclude();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic do_reset(input logic [2:0] m, input logic [2:0] p, input logic [1:0] c);
    @(posedge clk);
    sys_rst <= 1'b1;
    nv_osc_mode_field <= m;
    nv_presc_field <= p;
    nv_core_divider_field <= c;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic measure(input int cycles);
    logic last;
    c_usb = 0;
    c_pll = 0;
    c_per = 0;
    c_cpu = 0;
    c_tog = 0;
    c_ref = 0;
    @(negedge clk);
    last = osc_pin_two_out;
    repeat (cycles) begin
      @(negedge clk);
      c_usb += int'(usb_tick === 1'b1);
      c_pll += int'(pll_out_tick === 1'b1);
      c_per += int'(periph_tick === 1'b1);
      c_cpu += int'(cpu_tick === 1'b1);
      c_tog += int'(osc_pin_two_out !== last);
      c_ref += int'(pll_ref_tick === 1'b1);
      last = osc_pin_two_out;
    end
  endtask

  task automatic t_regs();
    do_reset(occ_pkg::MODE_EXT_PLL, 3'h2, 2'h1);
    wb(1'b0, occ_pkg::REG_CTRL, 4'hf, 32'h0);
    chk_word(q, 32'h0, "ctrl reset");
    wb(1'b0, 8'h40, 4'hf, 32'h0);
    chk_word(q, 32'h0, "unmapped read");
    wb(1'b1, occ_pkg::REG_CFG, 4'hf, 32'hffffffff);
    nv_osc_mode_field <= 3'h0;
    nv_presc_field <= 3'h7;
    wb(1'b0, occ_pkg::REG_CFG, 4'hf, 32'h0);
    chk_word(q, 32'h00000125, "cfg held");
    wb(1'b1, occ_pkg::REG_CTRL, 4'he, 32'h1);
    chk_bit(pll_power_en, 1'b0, "ctrl without sel0");
    $display("test regs done");
  endtask

  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      do_reset(m, m, m[1:0]);
      wb(1'b1, occ_pkg::REG_CTRL, 4'hf, 32'h1);
      chk_bit(pll_power_en, PLL_M[i], "pll power per mode");
      chk_bit(osc_pin_two_oe, CKO_M[i], "pin two drive");
      chk_bit(osc_pin_one_oe, ~EXT_M[i], "pin one drive");
      chk_bit(osc_pin_one_out, ~EXT_M[i], "pin one port data");
      chk_bit(xtal_drive_en, XT_M[i], "crystal drive");
      wb(1'b0, occ_pkg::REG_CFG, 4'hf, 32'h0);
      chk_word(q, {22'h0, m[1:0], 1'b0, m, 1'b0, m}, "cfg fields");
    end
    $display("test modes done");
  endtask

  task automatic t_lock();
    int n = 0;
    int cpu = 0;
    do_reset(occ_pkg::MODE_EXT_PLL, 3'h2, 2'h3);
    measure(30);
    chk_cnt(c_pll, 0, 0, "pll idle while off");
    // full speed node at 48 mhz
    wb(1'b1, occ_pkg::REG_CTRL, 4'hf, 32'h1);
    repeat (4 * LK) begin
      @(negedge clk);
      if (pll_locked === 1'b1) break;
      n++;
      cpu += int'(cpu_tick === 1'b1);
    end
    chk_bit(pll_locked, 1'b1, "lock reached");
    if (pll_locked !== 1'b1) begin
      conclude();
    end
    chk_cnt(n, LK, 1, "lock interval");
    chk_bit(cpu > 0, 1'b1, "core runs on bypass");
    // the glitch-free switch waits for a quiet cycle
    repeat (2) @(posedge clk);
    wb(1'b0, occ_pkg::REG_STAT, 4'hf, 32'h0);
    chk_word(q, 32'h0000001f, "status after lock");
    measure(240);
    chk_cnt(c_usb, c_pll / 2, 2, "usb full speed");
    chk_cnt(c_cpu, c_pll / 12, 2, "core divide by six");
    // pin one rises every 4 cycles, prescaler code 2 divides by three
    chk_cnt(c_ref, 20, 2, "reference prescaled");
    // low speed, usb at 6 mhz
    wb(1'b1, occ_pkg::REG_CTRL, 4'hf, 32'h9);
    measure(240);
    chk_cnt(c_usb, c_pll / 16, 2, "usb low speed");
    $display("test lock done");
  endtask

  task automatic t_sel();
    wb(1'b1, occ_pkg::REG_CTRL, 4'hf, 32'h1);
    chk_bit(usb_clk_ok, 1'b1, "usb on primary");
    for (int s = 1; s < 3; s++) begin
      wb(1'b1, occ_pkg::REG_CTRL, 4'hf, 32'(2 * s + 1));
      chk_bit(pll_power_en, 1'b0, "pll shut by sel");
      chk_bit(prim_osc_en, 1'b0, "primary shut by sel");
      chk_bit(usb_clk_ok, 1'b0, "usb off sel");
      refclk_needs_osc <= 1'b1;
      @(negedge clk);
      chk_bit(prim_osc_en, 1'b1, "primary kept for refclk");
      @(posedge clk);
      refclk_needs_osc <= 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(pll_locked, 1'b0, "lock lost");
    end
    $display("test sel done");
  endtask

  task automatic t_clkout();
    do_reset(occ_pkg::MODE_INT_CLKOUT, 3'h0, 2'h0);
    measure(200);
    chk_bit(c_per > 0, 1'b1, "periph running");
    chk_cnt(c_tog, c_per / 2, 1, "clock out quarter");
    @(posedge clk);
    sleep_mode <= 1'b1;
    measure(100);
    chk_cnt(c_tog, 0, 0, "clock out in sleep");
    @(posedge clk);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    measure(200);
    chk_cnt(c_tog, c_per / 2, 1, "clock out in idle");
    chk_cnt(c_cpu, 0, 0, "core stopped in idle");
    @(posedge clk);
    idle_mode <= 1'b0;
    $display("test clkout done");
  endtask

  initial begin
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {nv_osc_mode_field, nv_presc_field, nv_core_divider_field} = '0;
    {sleep_mode, idle_mode, refclk_needs_osc} = '0;
    {port_one_out, port_one_oe, port_two_out, port_two_oe} = 4'he;
    t_regs();
    t_modes();
    t_lock();
    t_sel();
    t_clkout();
    conclude();
  end
endmodule // occ_clk_ctrl_tb_top
